// >>> rtl/ulrd_cfg.svh
`ifndef ULRD_CFG_SVH
`define ULRD_CFG_SVH

// Register byte offsets
`define ULRD_CTRL_OFS        12'h000
`define ULRD_STAT_OFS        12'h004

// Control register field positions
`define ULRD_XCVR_LSB        0
`define ULRD_TERM_BIT        2
`define ULRD_OPMODE_LSB      3
`define ULRD_DPPD_BIT        5
`define ULRD_DMPD_BIT        6

// Status register field positions
`define ULRD_STAT_PU_BIT     0
`define ULRD_STAT_DPPD_BIT   1
`define ULRD_STAT_DMPD_BIT   2
`define ULRD_STAT_HST_BIT    3

// Transceiver select and operating mode codes
`define ULRD_XCVR_HS         2'h0
`define ULRD_XCVR_FS         2'h1
`define ULRD_XCVR_LS         2'h2
`define ULRD_OPMODE_NORMAL   2'h0
`define ULRD_OPMODE_NODRIVE  2'h1
`define ULRD_OPMODE_NOSTUFF  2'h2

// Power-up / session-end setting
`define ULRD_XCVR_RST        2'h1
`define ULRD_TERM_RST        1'h0
`define ULRD_OPMODE_RST      2'h0
`define ULRD_DPPD_RST        1'h1
`define ULRD_DMPD_RST        1'h1

`endif

// >>> rtl/ulrd_pkg.sv
package ulrd_pkg;

  typedef struct packed {
    logic       dm_pulldown;
    logic       dp_pulldown;
    logic [1:0] op_mode;
    logic       term_select;
    logic [1:0] xcvr_select;
  } ulrd_ctrl_t;

  typedef struct packed {
    logic hs_termination_on;
    logic dm_pulldown_on;
    logic dp_pulldown_on;
    logic dp_pullup_on;
  } ulrd_res_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
  } ulrd_apb_req_t;

  typedef struct packed {
    logic setup;
    logic wr_ctrl;
    logic sel_ctrl;
    logic sel_stat;
  } ulrd_apb_evt_t;

  typedef enum logic {
    ULRD_IDLE,
    ULRD_ACCESS
  } ulrd_phase_t;

endpackage : ulrd_pkg

// >>> rtl/ulrd_resistor_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "ulrd_cfg.svh"

module ulrd_resistor_decode
  import ulrd_pkg::*;
(
  input  wire ulrd_ctrl_t ctrl,
  output ulrd_res_t       res
);

  logic driving;

  always_comb begin
    driving = (ctrl.op_mode != `ULRD_OPMODE_NODRIVE);
    // pull-up only with term select and no DP pull-down
    res.dp_pullup_on      = driving && ctrl.term_select && !ctrl.dp_pulldown;
    res.dp_pulldown_on    = driving && ctrl.dp_pulldown;
    res.dm_pulldown_on    = driving && ctrl.dm_pulldown;
    // termination only for HS select with term select low
    res.hs_termination_on = driving && !ctrl.term_select &&
                            (ctrl.xcvr_select == `ULRD_XCVR_HS);
  end

endmodule : ulrd_resistor_decode
`default_nettype wire

// >>> rtl/ulrd_apb_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "ulrd_cfg.svh"

module ulrd_apb_port
  import ulrd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire ulrd_apb_req_t req,
  output ulrd_apb_evt_t      evt,
  output logic               pready,
  output logic               pslverr
);

  typedef struct packed {
    ulrd_phase_t phase;
  } ulrd_port_state_t;

  ulrd_port_state_t st_reg;
  ulrd_port_state_t st_next;
  logic             in_access;

  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      ULRD_IDLE: begin
        if (req.psel && !req.penable) begin
          st_next.phase = ULRD_ACCESS;
        end
      end
      ULRD_ACCESS: begin
        st_next.phase = ULRD_IDLE;
      end
      default: begin
        st_next.phase = ULRD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{phase: ULRD_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero wait states: every access completes at its first access edge
  assign in_access    = (st_reg.phase == ULRD_ACCESS) && req.psel && req.penable;
  assign evt.sel_ctrl = (req.paddr == `ULRD_CTRL_OFS);
  assign evt.sel_stat = (req.paddr == `ULRD_STAT_OFS);
  assign evt.setup    = req.psel && !req.penable;
  assign evt.wr_ctrl  = in_access && req.pwrite && evt.sel_ctrl;
  assign pready       = in_access;
  // Unmapped or misaligned addresses answer with an error, data zero
  assign pslverr      = in_access && !(evt.sel_ctrl || evt.sel_stat);

  chk_ready_after_setup: assert property (
    @(posedge clk) disable iff (!reset_n)
    (req.psel && !req.penable) ##1 (req.psel && req.penable) |-> pready)
    else $error("pready missing in first access cycle");

  chk_ready_needs_setup: assert property (
    @(posedge clk) disable iff (!reset_n)
    pready |-> $past(req.psel && !req.penable))
    else $error("pready without preceding setup");

endmodule : ulrd_apb_port
`default_nettype wire

// >>> rtl/ulrd_line_resistor.sv
`timescale 1ns/100ps
`default_nettype none
`include "ulrd_cfg.svh"

// Summary of operation
// - Resistor enables depend only on transceiver select, termination select, op mode and pull-down bits.
// - A DP pull-up enable output switches in the 1.5 kilohm DP pull-up.
// - Separate DP and DM pull-down enables each switch in a 15 kilohm pull-down.
// - One high-speed termination enable switches in the 45 ohm terminations on both lines.
// - Op mode 01b turns all four resistor enables off regardless of other bits.
// - Outside op mode 01b each pull-down enable follows its own control bit, power-up setting included.
// - HS termination is on exactly when select is 00b, term select is 0b and op mode is not 01b.
// - The DP pull-up is on only with term select 1b, DP pull-down bit 0b, outside op mode 01b.
// - Peripheral high-speed and test J/K enable only the HS termination.
// - Host full-speed, suspend and low-speed enable both pull-downs and nothing else.
// - Each resume setting (op mode 10b) gives the same enables as its suspend (00b).
// - In OTG peripheral states the DM pull-down stays on beside pull-up or termination.
// - Host and peripheral chirp settings force their matching resistor enables.
module ulrd_line_resistor
  import ulrd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             dp_pullup_on,
  output logic             dp_pulldown_on,
  output logic             dm_pulldown_on,
  output logic             hs_termination_on
);

  localparam ulrd_ctrl_t CTRL_RST = '{
    dm_pulldown: `ULRD_DMPD_RST,
    dp_pulldown: `ULRD_DPPD_RST,
    op_mode:     `ULRD_OPMODE_RST,
    term_select: `ULRD_TERM_RST,
    xcvr_select: `ULRD_XCVR_RST
  };

  typedef struct packed {
    ulrd_ctrl_t  ctrl;
    logic [31:0] rdata;
  } ulrd_state_t;

  ulrd_state_t   st_reg;
  ulrd_state_t   st_next;
  ulrd_apb_req_t req;
  ulrd_apb_evt_t evt;
  ulrd_res_t     res;
  logic [31:0]   ctrl_word;
  logic [31:0]   stat_word;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr};

  ulrd_apb_port u_port (
    .clk     (clk),
    .reset_n (reset_n),
    .req     (req),
    .evt     (evt),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // only the held control bits feed the decode
  ulrd_resistor_decode u_decode (
    .ctrl (st_reg.ctrl),
    .res  (res)
  );

  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[`ULRD_XCVR_LSB +: 2]   = st_reg.ctrl.xcvr_select;
    ctrl_word[`ULRD_TERM_BIT]        = st_reg.ctrl.term_select;
    ctrl_word[`ULRD_OPMODE_LSB +: 2] = st_reg.ctrl.op_mode;
    ctrl_word[`ULRD_DPPD_BIT]        = st_reg.ctrl.dp_pulldown;
    ctrl_word[`ULRD_DMPD_BIT]        = st_reg.ctrl.dm_pulldown;
    stat_word = 32'h0;
    stat_word[`ULRD_STAT_PU_BIT]     = res.dp_pullup_on;
    stat_word[`ULRD_STAT_DPPD_BIT]   = res.dp_pulldown_on;
    stat_word[`ULRD_STAT_DMPD_BIT]   = res.dm_pulldown_on;
    stat_word[`ULRD_STAT_HST_BIT]    = res.hs_termination_on;
  end

  always_comb begin
    st_next = st_reg;
    // Read data is captured in the setup cycle so prdata comes from a flop
    if (evt.setup) begin
      if (evt.sel_ctrl) begin
        st_next.rdata = ctrl_word;
      end else if (evt.sel_stat) begin
        st_next.rdata = stat_word;
      end else begin
        st_next.rdata = 32'h0;
      end
    end
    // the link picks the state; any combination is accepted as written
    // register write at the access edge
    if (evt.wr_ctrl && pstrb[0]) begin
      st_next.ctrl.xcvr_select = pwdata[`ULRD_XCVR_LSB +: 2];
      st_next.ctrl.term_select = pwdata[`ULRD_TERM_BIT];
      st_next.ctrl.op_mode     = pwdata[`ULRD_OPMODE_LSB +: 2];
      st_next.ctrl.dp_pulldown = pwdata[`ULRD_DPPD_BIT];
      st_next.ctrl.dm_pulldown = pwdata[`ULRD_DMPD_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{ctrl: CTRL_RST, rdata: 32'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata            = st_reg.rdata;
  assign dp_pullup_on      = res.dp_pullup_on;
  assign dp_pulldown_on    = res.dp_pulldown_on;
  assign dm_pulldown_on    = res.dm_pulldown_on;
  assign hs_termination_on = res.hs_termination_on;

  logic nodrive;
  logic hs_sel;
  logic fs_or_ls_sel;

  assign nodrive      = (st_reg.ctrl.op_mode == `ULRD_OPMODE_NODRIVE);
  assign hs_sel       = (st_reg.ctrl.xcvr_select == `ULRD_XCVR_HS) && !st_reg.ctrl.term_select;
  assign fs_or_ls_sel = (st_reg.ctrl.xcvr_select != `ULRD_XCVR_HS) && st_reg.ctrl.term_select;

  sequence s_ctrl_write;
    psel && penable && pready && pwrite && (paddr == `ULRD_CTRL_OFS) && pstrb[0];
  endsequence

  sequence s_suspend_resume_swap;
    fs_or_ls_sel && !nodrive ##1
    fs_or_ls_sel && !nodrive && $stable(st_reg.ctrl.xcvr_select) &&
    $stable(st_reg.ctrl.dp_pulldown) && $stable(st_reg.ctrl.dm_pulldown);
  endsequence

  // Bus steps shared by the register checks below
  sequence s_ctrl_setup;
    psel && !penable && (paddr == `ULRD_CTRL_OFS);
  endsequence

  sequence s_access_done;
    psel && penable && pready;
  endsequence

  sequence s_chirp_setting;
    !nodrive && (st_reg.ctrl.op_mode == `ULRD_OPMODE_NOSTUFF) &&
    (st_reg.ctrl.xcvr_select == `ULRD_XCVR_HS);
  endsequence

  chk_nodrive_all_off: assert property (
    @(posedge clk) disable iff (!reset_n)
    nodrive |-> !(dp_pullup_on || dp_pulldown_on || dm_pulldown_on || hs_termination_on))
    else $error("resistor enabled in non-driving mode");

  chk_pulldown_follow: assert property (
    @(posedge clk) disable iff (!reset_n)
    !nodrive |-> (dp_pulldown_on == st_reg.ctrl.dp_pulldown) &&
                 (dm_pulldown_on == st_reg.ctrl.dm_pulldown))
    else $error("pull-down enable does not follow control bit");

  chk_hsterm_exact: assert property (
    @(posedge clk) disable iff (!reset_n)
    hs_termination_on == (hs_sel && !nodrive))
    else $error("hs termination enable mismatch");

  chk_pullup_cause: assert property (
    @(posedge clk) disable iff (!reset_n)
    dp_pullup_on |-> st_reg.ctrl.term_select && !st_reg.ctrl.dp_pulldown && !nodrive)
    else $error("pull-up enabled without its settings");

  chk_periph_hs_only: assert property (
    @(posedge clk) disable iff (!reset_n)
    hs_sel && !nodrive && !st_reg.ctrl.dp_pulldown && !st_reg.ctrl.dm_pulldown
    |-> hs_termination_on && !dp_pullup_on && !dp_pulldown_on && !dm_pulldown_on)
    else $error("peripheral high-speed enables wrong");

  chk_host_fs_ls: assert property (
    @(posedge clk) disable iff (!reset_n)
    fs_or_ls_sel && !nodrive && st_reg.ctrl.dp_pulldown && st_reg.ctrl.dm_pulldown
    |-> dp_pulldown_on && dm_pulldown_on && !dp_pullup_on && !hs_termination_on)
    else $error("host full/low-speed enables wrong");

  chk_resume_same: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_suspend_resume_swap |-> $stable({dp_pullup_on, dp_pulldown_on,
                                       dm_pulldown_on, hs_termination_on}))
    else $error("resume enables differ from suspend");

  chk_otg_dm_kept: assert property (
    @(posedge clk) disable iff (!reset_n)
    !nodrive && !st_reg.ctrl.dp_pulldown && st_reg.ctrl.dm_pulldown &&
    (st_reg.ctrl.term_select || hs_sel)
    |-> dm_pulldown_on && !dp_pulldown_on && (dp_pullup_on ^ hs_termination_on))
    else $error("otg peripheral enables wrong");

  chk_chirp_forced: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_reg.ctrl.op_mode == `ULRD_OPMODE_NOSTUFF) &&
    (st_reg.ctrl.xcvr_select == `ULRD_XCVR_HS)
    |-> (hs_termination_on == !st_reg.ctrl.term_select) &&
        (dp_pullup_on == (st_reg.ctrl.term_select && !st_reg.ctrl.dp_pulldown)))
    else $error("chirp enables wrong");

  chk_write_lag: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_ctrl_write |=> (st_reg.ctrl.op_mode == $past(pwdata[`ULRD_OPMODE_LSB +: 2])) &&
                     (dp_pulldown_on == ($past(pwdata[`ULRD_DPPD_BIT]) &&
                      ($past(pwdata[`ULRD_OPMODE_LSB +: 2]) != `ULRD_OPMODE_NODRIVE))))
    else $error("write not reflected one cycle later");

  chk_status_read: assert property (
    @(posedge clk) disable iff (!reset_n)
    psel && !penable && (paddr == `ULRD_STAT_OFS) ##1 pready
    |-> prdata[3:0] == {hs_termination_on, dm_pulldown_on, dp_pulldown_on, dp_pullup_on})
    else $error("status read data mismatch");

  // Two sampled reset edges are needed: the flops are unknown before the first one
  chk_reset_powerup: assert property (
    @(posedge clk)
    !reset_n ##1 !reset_n |-> (st_reg.ctrl == CTRL_RST) && (prdata == 32'h0) &&
                             !dp_pullup_on && dp_pulldown_on && dm_pulldown_on &&
                             !hs_termination_on)
    else $error("reset does not give the power-up setting");

  chk_enables_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    $stable(st_reg.ctrl) |-> $stable({dp_pullup_on, dp_pulldown_on,
                                      dm_pulldown_on, hs_termination_on}))
    else $error("enables moved without a control change");

  chk_pullup_vs_pulldown: assert property (
    @(posedge clk) disable iff (!reset_n)
    dp_pullup_on |-> !dp_pulldown_on)
    else $error("pull-up and pull-down both on for DP");

  chk_pulldown_split: assert property (
    @(posedge clk) disable iff (!reset_n)
    !nodrive && (st_reg.ctrl.dp_pulldown != st_reg.ctrl.dm_pulldown)
    |-> (dp_pulldown_on != dm_pulldown_on))
    else $error("pull-downs not controlled separately");

  chk_term_no_pullup: assert property (
    @(posedge clk) disable iff (!reset_n)
    hs_termination_on |-> !dp_pullup_on && !st_reg.ctrl.term_select)
    else $error("termination on together with pull-up");

  // Row checks: one property per documented signalling state
  chk_powerup_row: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_reg.ctrl == CTRL_RST)
    |-> !dp_pullup_on && dp_pulldown_on && dm_pulldown_on && !hs_termination_on)
    else $error("power-up setting enables wrong");

  chk_host_hs_row: assert property (
    @(posedge clk) disable iff (!reset_n)
    hs_sel && !nodrive && st_reg.ctrl.dp_pulldown && st_reg.ctrl.dm_pulldown
    |-> hs_termination_on && dp_pulldown_on && dm_pulldown_on && !dp_pullup_on)
    else $error("host high-speed enables wrong");

  chk_periph_fs_row: assert property (
    @(posedge clk) disable iff (!reset_n)
    fs_or_ls_sel && !nodrive && !st_reg.ctrl.dp_pulldown
    |-> dp_pullup_on && !dp_pulldown_on && !hs_termination_on)
    else $error("peripheral full-speed enables wrong");

  chk_host_chirp_row: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_chirp_setting ##0 (!st_reg.ctrl.term_select && st_reg.ctrl.dp_pulldown)
    |-> hs_termination_on && dp_pulldown_on && !dp_pullup_on)
    else $error("host chirp enables wrong");

  chk_periph_chirp_row: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_chirp_setting ##0 (st_reg.ctrl.term_select && !st_reg.ctrl.dp_pulldown)
    |-> dp_pullup_on && !dp_pulldown_on && !hs_termination_on)
    else $error("peripheral chirp enables wrong");

  chk_otg_chirp_row: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_chirp_setting ##0 (st_reg.ctrl.term_select && st_reg.ctrl.dm_pulldown)
    |-> dm_pulldown_on && !hs_termination_on)
    else $error("otg chirp enables wrong");

  chk_ctrl_readback: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_ctrl_setup ##1 s_access_done |-> (prdata == {25'h0, st_reg.ctrl}))
    else $error("control read data mismatch");

  chk_write_takes: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_access_done ##0 (pwrite && pstrb[0] && (paddr == `ULRD_CTRL_OFS))
    |=> (st_reg.ctrl == $past(pwdata[6:0])))
    else $error("control write not taken");

  // Any write that misses the control byte must leave the setting alone
  chk_write_refused: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_access_done ##0 (pwrite && !(pstrb[0] && (paddr == `ULRD_CTRL_OFS)))
    |=> $stable(st_reg.ctrl))
    else $error("refused write changed the control setting");

  chk_error_zero_data: assert property (
    @(posedge clk) disable iff (!reset_n)
    pready && pslverr |-> (prdata == 32'h0))
    else $error("error response with non-zero data");

  chk_mapped_no_error: assert property (
    @(posedge clk) disable iff (!reset_n)
    pready && ((paddr == `ULRD_CTRL_OFS) || (paddr == `ULRD_STAT_OFS)) |-> !pslverr)
    else $error("error response on a mapped register");

  chk_pslverr_needs_ready: assert property (
    @(posedge clk) disable iff (!reset_n)
    pslverr |-> pready)
    else $error("error response outside an access cycle");

  chk_idle_quiet: assert property (
    @(posedge clk) disable iff (!reset_n)
    !psel |-> !pready && !pslverr)
    else $error("bus answer without a selected transfer");

  chk_ready_one_cycle: assert property (
    @(posedge clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  // Read data is a flop that only a setup cycle reloads
  chk_rdata_held: assert property (
    @(posedge clk) disable iff (!reset_n)
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");

endmodule : ulrd_line_resistor
`default_nettype wire

// >>> sim/ulrd_link_model.sv
`timescale 1ns/100ps
`default_nettype none

module ulrd_link_model (
  input  wire logic        clk,
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input int gap,
                      output logic [31:0] rd, output logic err);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the bench watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale address or write data; pwrite and pstrb keep their values
    pwdata <= ~d;
    paddr <= ~a;
  endtask : xfer
endmodule : ulrd_link_model

`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ulrd_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  res;
  int          error_cnt = 0;
  int          check_count = 0;
  int          seed = 32'h96b7;
  logic [31:0] rd;
  logic        err;
  logic [6:0]  rows [20] = '{7'h6f, 7'h08, 7'h61, 7'h70, 7'h60, 7'h65, 7'h67, 7'h75, 7'h66,
                             7'h76, 7'h14, 7'h00, 7'h05, 7'h15, 7'h10, 7'h54, 7'h40,
                             7'h45, 7'h55, 7'h50};
  // Enables per row as {termination, dm pull-down, dp pull-down, pull-up}
  logic [3:0]  want [20] = '{4'h0, 4'h0, 4'h6, 4'he, 4'he, 4'h6, 4'h6, 4'h6, 4'h6, 4'h6,
                             4'h1, 4'h8, 4'h1, 4'h1, 4'h8, 4'h5, 4'hc, 4'h5, 4'h5, 4'hc};

  always #20 clk = ~clk;

  ulrd_line_resistor dut (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dp_pullup_on(res[0]), .dp_pulldown_on(res[1]),
    .dm_pulldown_on(res[2]), .hs_termination_on(res[3]));

  ulrd_link_model link (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Order {termination, dm pull-down, dp pull-down, pull-up}
  function automatic logic [3:0] expect_res(input logic [6:0] c);
    logic drv;
    drv = (c[4:3] != 2'h1);
    return {drv & ~c[2] & (c[1:0] == 2'h0), drv & c[6], drv & c[5], drv & c[2] & ~c[5]};
  endfunction : expect_res

  task automatic apply(input logic [6:0] c, input int gap);
    link.xfer(1'b1, 12'h000, ({$random(seed)} & 32'hffffff80) | {25'h0, c}, 4'h1, gap, rd, err);
    #1;
    check({28'h0, res}, {28'h0, expect_res(c)});
    link.xfer(1'b0, 12'h004, 32'h0, 4'h0, 0, rd, err);
    check(rd, {28'h0, expect_res(c)});
    link.xfer(1'b0, 12'h000, 32'h0, 4'h0, 0, rd, err);
    check(rd, {25'h0, c});
  endtask : apply

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #2000000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check({28'h0, res}, 32'h6);
    link.xfer(1'b0, 12'h000, 32'h0, 4'h0, 0, rd, err);
    check(rd, 32'h61);
    $display("test reset done");
    foreach (rows[i]) begin
      apply(rows[i], i % 3);
      check({28'h0, res}, {28'h0, want[i]});
    end
    $display("test state table done");
    for (int i = 0; i < 40; i++) apply(7'($random(seed)), i % 2);
    $display("test random done");
    apply(rows[19], 0);
    link.xfer(1'b1, 12'h000, 32'h0000_0000, 4'he, 0, rd, err);
    link.xfer(1'b1, 12'h004, 32'h0000_000f, 4'hf, 1, rd, err);
    #1;
    check({31'h0, err}, 32'h0);
    check({28'h0, res}, {28'h0, expect_res(rows[19])});
    link.xfer(1'b0, 12'h008, 32'h0, 4'h0, 0, rd, err);
    check({rd[30:0], err}, 32'h1);
    link.xfer(1'b0, 12'h002, 32'h0, 4'h0, 2, rd, err);
    check({31'h0, err}, 32'h1);
    $display("test refusals done");
    apply(7'h14, 0);
    @(posedge clk);
    reset_n <= 1'b0;
    #1;
    check({28'h0, res}, 32'h6);
    @(posedge clk);
    reset_n <= 1'b1;
    apply(7'h6f, 0);
    $display("test second reset done");
    give_verdict();
  end
endmodule : testbench

`default_nettype wire
